// >>> core/npc_pkg.sv
// package for the nvm page program controller: offsets, commands, timing
package npc_pkg;
  localparam logic [3:0] NPC_OFS_CONTROL_A    = 4'h0;
  localparam logic [3:0] NPC_OFS_CONTROL_B    = 4'h1;
  localparam logic [3:0] NPC_OFS_STATUS   = 4'h2;
  localparam logic [3:0] NPC_OFS_INTCTRL  = 4'h3;
  localparam logic [3:0] NPC_OFS_INTFLAGS = 4'h4;
  localparam logic [3:0] NPC_OFS_DATAL    = 4'h6;
  localparam logic [3:0] NPC_OFS_DATAH    = 4'h7;
  localparam logic [3:0] NPC_OFS_ADDRL    = 4'h8;
  localparam logic [3:0] NPC_OFS_ADDRH    = 4'h9;
  localparam logic [3:0] NPC_OFS_CCP      = 4'hA;
  localparam logic [7:0] NPC_KEY_SPM      = 8'h9D;
  localparam logic [7:0] NPC_KEY_IO_UNLOCK_KEY    = 8'hD8;
  localparam logic [2:0] NPC_KEY_WINDOW   = 3'h4;
  localparam logic [2:0] NPC_CLR_CYCLES   = 3'h7;
  localparam logic [7:0] NPC_RESET_BYTE   = 8'h00;
  typedef enum logic [2:0] {
    NPC_CMD_NONE  = 3'b000,
    NPC_CMD_WP    = 3'b001,
    NPC_CMD_ER    = 3'b010,
    NPC_CMD_ERASE_WRITE_CMD  = 3'b011,
    NPC_CMD_PBC   = 3'b100,
    NPC_CMD_CHIP_ERASE_CMD  = 3'b101,
    NPC_CMD_EEPROM_ERASE_CMD  = 3'b110,
    NPC_CMD_WFU   = 3'b111
  } npc_cmd_e;
  typedef enum logic [1:0] {
    NPC_SEC_BOOT = 2'b00,
    NPC_SEC_CODE = 2'b01,
    NPC_SEC_DATA = 2'b10,
    NPC_SEC_EE   = 2'b11
  } npc_sec_e;
  typedef enum logic [2:0] {
    NPC_ST_IDLE  = 3'b000,
    NPC_ST_ERASE = 3'b001,
    NPC_ST_WRITE = 3'b010,
    NPC_ST_CLEAR = 3'b011,
    NPC_ST_BULK  = 3'b100,
    NPC_ST_FUSE  = 3'b101,
    NPC_ST_TOUT  = 3'b110
  } npc_state_e;
endpackage

// >>> core/npc_ctrl.sv
// nvm page program controller: protection, page buffer and command sequencer
// Operation
// - boot writes code/data, code writes data only
// - boot read lock set from boot, acts after leaving
// - code write protect blocks app code updates
// - eeprom ops touch only marked bytes
// - user row: eeprom page, kept, port writable
// - array reads stall while operation runs
// - shared page buffer, stores AND into it
// - buffer reset to ones on reset/op (except fuse write)/clear/wake
// - page write copies buffer, halts cpu for flash
// - page erase needs one marked byte
// - eeprom erase only marked bytes, cpu runs
// - erase-write keeps buffer between phases
// - buffer clear halts cpu seven cycles
// - chip erase ignores locks, honours preserve fuse
// - eeprom erase wipes all, cpu halted
// - fuse write only from program port
// - post-reset timeout rejects writes, busy high
// - reset aborts an ongoing write
// - irq = enable and flag, level
// - sleep deferred while write runs
// - protected registers need their key
// - command field decode 0 to 7
// - ready flag set while eeprom idle
// - locked boot reads return zero
`default_nettype none
module npc_ctrl
  import npc_pkg::*;
#(
  parameter int PAGE_BYTES = 32,
  parameter int AW         = 16,
  parameter int TOUT_CYC   = 64
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire logic          port_access,
  input  wire logic [1:0]    exec_section,
  input  wire logic          mem_wr,
  input  wire logic          mem_rd,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [1:0]    mem_section,
  input  wire logic          mem_user_row,
  input  wire logic [7:0]    mem_wdata,
  input  wire logic [7:0]    array_rdata,
  output logic [7:0]         mem_rdata,
  output logic               mem_rvalid,
  output logic               mem_wait,
  output logic               cpu_halt,
  output logic               array_start,
  output logic [2:0]         array_op,
  output logic [AW-1:0]      array_addr,
  output logic               array_eeprom,
  output logic               array_user_row,
  output logic               array_keep_ee,
  input  wire logic          array_done,
  output logic [7:0]         buf_rd_byte,
  output logic               buf_rd_mark,
  input  wire logic          eeprom_preserve_fuse,
  input  wire logic          timeout_disable_fuse,
  input  wire logic          reset_pin_config,
  input  wire logic          device_locked,
  input  wire logic          sleep_req,
  input  wire logic          wake,
  output logic               sleep_ok,
  output logic               eeprom_ready_irq,
  output logic               write_error
);
  localparam int IW = $clog2(PAGE_BYTES);
  localparam logic [15:0] TOUT_N = 16'(TOUT_CYC);

  typedef struct packed {
    npc_state_e                 st;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0]      mark;
    logic [AW-1:0]              addr;
    logic [15:0]                data;
    logic                       tgt_ee;
    logic                       tgt_ur;
    logic                       erase_write_cmd;
    logic [2:0]                 op;
    logic                       started;
    logic [15:0]                cnt;
    logic [2:0]                 spm_win;
    logic [2:0]                 io_win;
    logic                       boot_lock_arm;
    logic                       boot_read_lock;
    logic                       app_code_write_protect;
    logic                       ie;
    logic                       flag;
    logic                       flash_busy_flag;
    logic                       eeprom_busy_flag;
    logic                       werr;
    logic                       rd_pend;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       halt;
    logic                       sleep_ok;
    logic                       irq;
    logic                       start;
    logic [7:0]                 ibyte;
    logic                       imark;
  } npc_s;

  npc_s s_q, s_d;
  logic [IW-1:0] widx, ridx;
  logic          wr_allowed, any_mark, op_busy;

  assign widx = mem_addr[IW-1:0];
  assign ridx = array_addr[IW-1:0];
  assign any_mark = |s_q.mark;
  assign op_busy = s_q.st != NPC_ST_IDLE;

  // ==========================================================================
  // write permission check
  always_comb begin
    wr_allowed = 1'b0;
    if (port_access) begin
      wr_allowed = 1'b1;
    end else if (exec_section == NPC_SEC_BOOT) begin
      wr_allowed = mem_section != NPC_SEC_BOOT;
    end else if (exec_section == NPC_SEC_CODE) begin
      wr_allowed = mem_section == NPC_SEC_DATA || mem_section == NPC_SEC_EE;
    end
    if (mem_section == NPC_SEC_CODE && s_q.app_code_write_protect && !port_access) begin
      wr_allowed = 1'b0;
    end
    if (mem_user_row && port_access && device_locked) begin
      wr_allowed = 1'b1;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.rdata = NPC_RESET_BYTE;
    s_d.ibyte = s_q.pbuf[ridx];
    s_d.imark = s_q.mark[ridx];
    if (s_q.spm_win != 3'h0) s_d.spm_win = s_q.spm_win - 3'h1;
    if (s_q.io_win != 3'h0) s_d.io_win = s_q.io_win - 3'h1;
    // lock takes effect once execution leaves boot
    if (s_q.boot_lock_arm && exec_section != NPC_SEC_BOOT) begin
      s_d.boot_read_lock = 1'b1;
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        NPC_OFS_CCP: begin
          if (reg_wdata == NPC_KEY_SPM) s_d.spm_win = NPC_KEY_WINDOW;
          if (reg_wdata == NPC_KEY_IO_UNLOCK_KEY) s_d.io_win = NPC_KEY_WINDOW;
        end
        NPC_OFS_CONTROL_A: begin
          if (s_q.spm_win != 3'h0 && !op_busy) begin
            s_d.spm_win = 3'h0;
            s_d.op = reg_wdata[2:0];
            s_d.werr = 1'b0;
            unique case (npc_cmd_e'(reg_wdata[2:0]))
              NPC_CMD_WP, NPC_CMD_ERASE_WRITE_CMD: begin
                s_d.st = NPC_ST_WRITE;
                s_d.erase_write_cmd = reg_wdata[1];
                if (reg_wdata[1]) s_d.st = NPC_ST_ERASE;
                s_d.start = 1'b1;
              end
              NPC_CMD_ER: begin
                if (any_mark) begin
                  s_d.st = NPC_ST_ERASE;
                  s_d.erase_write_cmd = 1'b0;
                  s_d.start = 1'b1;
                end
              end
              NPC_CMD_PBC: begin
                s_d.st = NPC_ST_CLEAR;
                s_d.cnt = 16'(NPC_CLR_CYCLES);
              end
              NPC_CMD_CHIP_ERASE_CMD, NPC_CMD_EEPROM_ERASE_CMD: begin
                s_d.st = NPC_ST_BULK;
                s_d.tgt_ee = reg_wdata[1];
                s_d.start = 1'b1;
              end
              NPC_CMD_WFU: begin
                if (port_access) begin
                  s_d.st = NPC_ST_FUSE;
                  s_d.start = 1'b1;
                end else begin
                  s_d.werr = 1'b1;
                end
              end
              default: ;
            endcase
            if (s_d.st != NPC_ST_IDLE && s_d.st != NPC_ST_CLEAR) begin
              s_d.flash_busy_flag = !s_d.tgt_ee || reg_wdata[2:0] == NPC_CMD_CHIP_ERASE_CMD;
              s_d.eeprom_busy_flag = s_d.tgt_ee || reg_wdata[2:0] == NPC_CMD_CHIP_ERASE_CMD;
              s_d.halt = !s_d.tgt_ee || reg_wdata[2];
            end
            if (s_d.st == NPC_ST_CLEAR) s_d.halt = 1'b1;
          end
        end
        NPC_OFS_CONTROL_B: begin
          if (s_q.io_win != 3'h0) begin
            s_d.io_win = 3'h0;
            if (reg_wdata[0]) s_d.app_code_write_protect = 1'b1;
            if (reg_wdata[1] && exec_section == NPC_SEC_BOOT) begin
              s_d.boot_lock_arm = 1'b1;
            end
          end
        end
        NPC_OFS_INTCTRL:  s_d.ie = reg_wdata[0];
        NPC_OFS_INTFLAGS: if (reg_wdata[0]) s_d.flag = 1'b0;
        NPC_OFS_DATAL:    s_d.data[7:0] = reg_wdata;
        NPC_OFS_DATAH:    s_d.data[15:8] = reg_wdata;
        NPC_OFS_ADDRL:    s_d.addr[7:0] = reg_wdata;
        NPC_OFS_ADDRH:    s_d.addr[AW-1:8] = reg_wdata[AW-9:0];
        default: ;
      endcase
    end
    // register reads, answered the next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        NPC_OFS_CONTROL_A:    s_d.rdata = {5'h00, s_q.op};
        NPC_OFS_CONTROL_B:    s_d.rdata = {6'h00, s_q.boot_lock_arm, s_q.app_code_write_protect};
        NPC_OFS_STATUS:   s_d.rdata = {5'h00, s_q.werr, s_q.eeprom_busy_flag, s_q.flash_busy_flag};
        NPC_OFS_INTCTRL:  s_d.rdata = {7'h00, s_q.ie};
        NPC_OFS_INTFLAGS: s_d.rdata = {7'h00, s_q.flag};
        NPC_OFS_DATAL:    s_d.rdata = s_q.data[7:0];
        NPC_OFS_DATAH:    s_d.rdata = s_q.data[15:8];
        NPC_OFS_ADDRL:    s_d.rdata = s_q.addr[7:0];
        NPC_OFS_ADDRH:    s_d.rdata = 8'(s_q.addr[AW-1:8]);
        default:          s_d.rdata = NPC_RESET_BYTE;
      endcase
    end
    // page buffer load: AND into the buffer and mark the byte
    if (mem_wr && !s_q.flash_busy_flag && !s_q.eeprom_busy_flag) begin
      if (wr_allowed) begin
        s_d.pbuf[widx] = s_q.pbuf[widx] & mem_wdata;
        s_d.mark[widx] = 1'b1;
        s_d.addr = mem_addr;
        s_d.tgt_ee = mem_section == NPC_SEC_EE;
        s_d.tgt_ur = mem_user_row;
      end else begin
        s_d.werr = 1'b1;
      end
    end
    // array reads wait out any running operation
    if (mem_rd || s_q.rd_pend) begin
      if (op_busy) begin
        s_d.rd_pend = 1'b1;
      end else begin
        s_d.rd_pend = 1'b0;
        s_d.rvalid = 1'b1;
        s_d.rdata = (mem_section == NPC_SEC_BOOT && s_q.boot_read_lock)
                    ? NPC_RESET_BYTE : array_rdata;
      end
    end
    // sequencer
    unique case (s_q.st)
      NPC_ST_TOUT: begin
        s_d.cnt = s_q.cnt - 16'h1;
        if (s_q.cnt == 16'h1) begin
          s_d.st = NPC_ST_IDLE;
          s_d.flash_busy_flag = 1'b0;
          s_d.eeprom_busy_flag = 1'b0;
        end
      end
      NPC_ST_CLEAR: begin
        s_d.cnt = s_q.cnt - 16'h1;
        if (s_q.cnt == 16'h1) begin
          s_d.st = NPC_ST_IDLE;
          s_d.halt = 1'b0;
          s_d.pbuf = '1;
          s_d.mark = '0;
        end
      end
      NPC_ST_ERASE, NPC_ST_WRITE, NPC_ST_BULK, NPC_ST_FUSE: begin
        if (array_done) begin
          if (s_q.st == NPC_ST_ERASE && s_q.erase_write_cmd) begin
            s_d.st = NPC_ST_WRITE;
            s_d.start = 1'b1;
          end else begin
            s_d.st = NPC_ST_IDLE;
            s_d.flash_busy_flag = 1'b0;
            s_d.eeprom_busy_flag = 1'b0;
            s_d.halt = 1'b0;
            if (s_q.st != NPC_ST_FUSE) begin
              s_d.pbuf = '1;
              s_d.mark = '0;
            end
          end
        end
      end
      default: ;
    endcase
    if (wake && !op_busy) begin
      s_d.pbuf = '1;
      s_d.mark = '0;
    end
    if (!s_d.eeprom_busy_flag) s_d.flag = 1'b1;
    s_d.irq = s_d.ie && s_d.flag;
    s_d.sleep_ok = sleep_req && s_d.st == NPC_ST_IDLE;
  end

  // ==========================================================================
  // state register; reset drops any running operation
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.pbuf <= '1;
      s_q.st <= NPC_ST_TOUT;
      s_q.cnt <= TOUT_N;
      s_q.flash_busy_flag <= 1'b1;
      s_q.eeprom_busy_flag <= 1'b1;
    end else if (s_q.st == NPC_ST_TOUT && (!timeout_disable_fuse || reset_pin_config)) begin
      s_q <= s_d;
      s_q.st <= NPC_ST_IDLE;
      s_q.flash_busy_flag <= 1'b0;
      s_q.eeprom_busy_flag <= 1'b0;
      s_q.flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata        = s_q.rdata;
  assign mem_rdata        = s_q.rdata;
  assign mem_rvalid       = s_q.rvalid;
  assign mem_wait         = s_q.rd_pend;
  assign cpu_halt         = s_q.halt;
  assign array_start      = s_q.start;
  assign array_op         = s_q.st == NPC_ST_ERASE ? NPC_CMD_ER : s_q.op;
  assign array_addr       = s_q.addr;
  assign array_eeprom     = s_q.tgt_ee;
  assign array_user_row   = s_q.tgt_ur && s_q.op != NPC_CMD_CHIP_ERASE_CMD;
  assign array_keep_ee    = eeprom_preserve_fuse;
  assign buf_rd_byte      = s_q.ibyte;
  assign buf_rd_mark      = s_q.imark;
  assign sleep_ok         = s_q.sleep_ok;
  assign eeprom_ready_irq = s_q.irq;
  assign write_error      = s_q.werr;

  // ==========================================================================
  // checks
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.ie && s_q.flag) |-> eeprom_ready_irq)
    else $error("irq not raised");
  AST_WFU_CPU: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == NPC_ST_IDLE && reg_wr && reg_addr == NPC_OFS_CONTROL_A
     && reg_wdata[2:0] == NPC_CMD_WFU && !port_access) |=> s_q.st != NPC_ST_FUSE)
    else $error("cpu started fuse write");
  AST_PBC_SEVEN: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(s_q.st == NPC_ST_CLEAR)) |-> cpu_halt [*7] ##1 !cpu_halt)
    else $error("buffer clear halt length wrong");
  AST_ER_NEEDS_MARK: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == NPC_ST_IDLE && !any_mark && s_q.spm_win != 3'h0 && reg_wr
     && reg_addr == NPC_OFS_CONTROL_A && reg_wdata[2:0] == NPC_CMD_ER) |=> !array_start)
    else $error("erase with empty buffer");
  AST_CONTROL_B_KEY: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == NPC_OFS_CONTROL_B && s_q.io_win == 3'h0)
    |=> $stable(s_q.app_code_write_protect))
    else $error("control b changed without key");
  AST_READ_STALL: assert property (@(posedge clk) disable iff (!rstn)
    (mem_rd && op_busy) |=> mem_wait && !mem_rvalid)
    else $error("read not stalled");
  AST_BUSY_DROP: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == NPC_ST_WRITE && array_done) |=> !s_q.flash_busy_flag && !s_q.eeprom_busy_flag)
    else $error("busy not cleared on completion");
  AST_CLEAR_ONES: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == NPC_ST_WRITE && array_done) |=> (s_q.mark == '0 && &s_q.pbuf))
    else $error("buffer not cleared after write");
  AST_CODE_WP: assert property (@(posedge clk) disable iff (!rstn)
    (mem_wr && !port_access && !s_q.flash_busy_flag && !s_q.eeprom_busy_flag && s_q.app_code_write_protect
     && mem_section == NPC_SEC_CODE) |=> write_error)
    else $error("protected code write accepted");
endmodule
`default_nettype wire

// >>> verif/npc_array_model.sv
// behavioural nvm array that answers each phase started by the controller
`default_nettype none
module npc_array_model #(
  parameter int LAT = 8
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       array_start,
  input  wire logic [2:0] array_op,
  input  wire logic [7:0] buf_rd_byte,
  input  wire logic       buf_rd_mark,
  output logic            array_done,
  output logic      [7:0] array_rdata,
  output logic      [7:0] cap_byte,
  output logic            cap_mark
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // ==========================================================
  // phase timing
  // mid-operation the data lines wander, so a read let through early shows up
  assign array_rdata = (cnt != 0) ? (cnt[7:0] ^ 8'h5A) : 8'hA5;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt        <= 0;
      array_done <= 1'b0;
      cap_byte   <= 8'h00;
      cap_mark   <= 1'b0;
    end else begin
      array_done <= 1'b0;
      if (array_start) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          array_done <= 1'b1;
          // erase phases carry no data worth keeping
          if (array_op != 3'h2) begin
            cap_byte <= buf_rd_byte;
            cap_mark <= buf_rd_mark;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/npc_ctrl_tb_top.sv
// self-checking testbench for the nvm page program controller
`default_nettype none
module npc_ctrl_tb_top;
  import npc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [1:0] sec; logic [2:0] cmd; logic [2:0] op; logic tchk; logic ee;
    logic halt; logic [7:0] busy; logic cap; logic [7:0] data;
  } npc_row_s;
  npc_row_s rows [6] = '{
    '{NPC_SEC_CODE, NPC_CMD_WP, 3'h1, 1'b1, 1'b0, 1'b1, 8'h01, 1'b1, 8'h3C},
    '{NPC_SEC_EE, NPC_CMD_WP, 3'h1, 1'b1, 1'b1, 1'b0, 8'h02, 1'b1, 8'h5A},
    '{NPC_SEC_EE, NPC_CMD_ER, 3'h2, 1'b1, 1'b1, 1'b0, 8'h02, 1'b0, 8'h00},
    '{NPC_SEC_CODE, NPC_CMD_ERASE_WRITE_CMD, 3'h2, 1'b1, 1'b0, 1'b1, 8'h01, 1'b1, 8'hC3},
    '{NPC_SEC_EE, NPC_CMD_CHIP_ERASE_CMD, 3'h5, 1'b0, 1'b0, 1'b0, 8'h03, 1'b0, 8'h00},
    '{NPC_SEC_EE, NPC_CMD_EEPROM_ERASE_CMD, 3'h6, 1'b1, 1'b1, 1'b1, 8'h02, 1'b0, 8'h00}};
  logic        clk, rstn, reg_wr, reg_rd, port_access, mem_wr, mem_rd, mem_user_row;
  logic        mem_rvalid, mem_wait, cpu_halt, array_start, array_eeprom, array_user_row;
  logic        array_keep_ee, array_done, buf_rd_mark, cap_mark, eeprom_preserve_fuse;
  logic        timeout_disable_fuse, reset_pin_config, device_locked, sleep_req, wake;
  logic        sleep_ok, eeprom_ready_irq, write_error;
  logic [1:0]  exec_section, mem_section;
  logic [2:0]  array_op;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata, array_rdata, buf_rd_byte, cap_byte;
  logic [7:0]  v;
  logic [15:0] mem_addr, array_addr;
  int          miscompares, checked, k;
  npc_ctrl #(.TOUT_CYC(8)) npc_ctrl_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_access(port_access), .exec_section(exec_section), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_section(mem_section), .mem_user_row(mem_user_row),
    .mem_wdata(mem_wdata), .array_rdata(array_rdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .mem_wait(mem_wait), .cpu_halt(cpu_halt),
    .array_start(array_start), .array_op(array_op), .array_addr(array_addr),
    .array_eeprom(array_eeprom), .array_user_row(array_user_row),
    .array_keep_ee(array_keep_ee), .array_done(array_done), .buf_rd_byte(buf_rd_byte),
    .buf_rd_mark(buf_rd_mark), .eeprom_preserve_fuse(eeprom_preserve_fuse),
    .timeout_disable_fuse(timeout_disable_fuse), .reset_pin_config(reset_pin_config),
    .device_locked(device_locked), .sleep_req(sleep_req), .wake(wake), .sleep_ok(sleep_ok),
    .eeprom_ready_irq(eeprom_ready_irq), .write_error(write_error));
  npc_array_model #(.LAT(8)) npc_array_model_i (.clk(clk), .rstn(rstn),
    .array_start(array_start), .array_op(array_op), .buf_rd_byte(buf_rd_byte),
    .buf_rd_mark(buf_rd_mark), .array_done(array_done), .array_rdata(array_rdata),
    .cap_byte(cap_byte), .cap_mark(cap_mark));
  // ==========================================================
  // bus and check tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic store(input logic [1:0] s, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); mem_section <= s; mem_addr <= a; mem_wdata <= d; mem_wr <= 1'b1;
    @(posedge clk); mem_wr <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c);
    wr(NPC_OFS_CCP, NPC_KEY_SPM);
    wr(NPC_OFS_CONTROL_A, {5'h00, c});
  endtask
  task automatic wait_start();
    k = 0;
    #1;
    while (array_start !== 1'b1 && k < 40) begin @(posedge clk); #1; k++; end
    chk("array_start", {15'h0, array_start}, 16'h1);
  endtask
  task automatic exp_none();
    k = 0;
    repeat (12) begin #1; if (array_start === 1'b1) k++; @(posedge clk); end
    chk("refused start", k[15:0], 16'h0);
  endtask
  task automatic idle_wait();
    k = 0;
    do begin rd(NPC_OFS_STATUS, v); k++; end while ((v & 8'h03) !== 8'h00 && k < 100);
    chk("busy clears", {8'h0, v & 8'h03}, 16'h0);
  endtask
  task automatic do_reset(input logic tdis);
    @(posedge clk); rstn <= 1'b0; timeout_disable_fuse <= tdis;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
  endtask
  // ==========================================================
  // stimulus
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  initial begin #(20000 * 50); miscompares++; end_sim(); end
  initial begin
    {rstn, reg_wr, reg_rd, port_access, mem_wr, mem_rd, mem_user_row} = '0;
    {eeprom_preserve_fuse, reset_pin_config, device_locked, sleep_req, wake} = '0;
    {reg_addr, reg_wdata, mem_wdata, mem_addr} = '0;
    exec_section = NPC_SEC_BOOT; mem_section = NPC_SEC_EE; timeout_disable_fuse = 1'b1;
    miscompares = 0; checked = 0;
    do_reset(1'b1);
    rd(NPC_OFS_STATUS, v); chk("busy in timeout", {8'h0, v & 8'h03}, 16'h3);
    repeat (12) @(posedge clk);
    rd(NPC_OFS_STATUS, v); chk("busy after timeout", {8'h0, v & 8'h03}, 16'h0);
    rd(NPC_OFS_INTFLAGS, v); chk("ready flag", {8'h0, v & 8'h01}, 16'h1);
    wr(NPC_OFS_INTCTRL, 8'h01); repeat (2) @(posedge clk); #1;
    chk("irq", {15'h0, eeprom_ready_irq}, 16'h1);
    wr(NPC_OFS_INTCTRL, 8'h00); repeat (2) @(posedge clk); #1;
    chk("irq off", {15'h0, eeprom_ready_irq}, 16'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      store(rows[i].sec, 16'h0104, rows[i].data);
      cmd(rows[i].cmd);
      wait_start();
      chk("op", {13'h0, array_op}, {13'h0, rows[i].op});
      @(posedge clk); #1;
      if (rows[i].tchk) begin
        chk("halt", {15'h0, cpu_halt}, {15'h0, rows[i].halt});
        chk("eeprom", {15'h0, array_eeprom}, {15'h0, rows[i].ee});
      end
      rd(NPC_OFS_STATUS, v); chk("busy", {8'h0, v & 8'h03}, {8'h0, rows[i].busy});
      idle_wait();
      if (rows[i].cap) chk("written", {7'h0, cap_mark, cap_byte}, {8'h1, rows[i].data});
      chk("buffer", {7'h0, buf_rd_mark, buf_rd_byte}, 16'h00FF);
      $display("test row %0d done", i);
    end
    store(NPC_SEC_EE, 16'h0008, 8'hF0); store(NPC_SEC_EE, 16'h0008, 8'h3C);
    cmd(NPC_CMD_WP); wait_start(); idle_wait();
    chk("and load", {7'h0, cap_mark, cap_byte}, 16'h0130);
    wr(NPC_OFS_CONTROL_A, 8'h01); exp_none();
    wr(NPC_OFS_CCP, NPC_KEY_IO_UNLOCK_KEY); wr(NPC_OFS_CONTROL_A, 8'h01); exp_none();
    store(NPC_SEC_CODE, 16'h0104, 8'h00); cmd(NPC_CMD_PBC); k = 0;
    repeat (20) begin #1; if (cpu_halt === 1'b1) k++; @(posedge clk); end
    chk("clear halt", k[15:0], {13'h0, NPC_CLR_CYCLES});
    store(NPC_SEC_EE, 16'h0010, 8'h11); cmd(NPC_CMD_WP); wait_start();
    @(posedge clk); sleep_req <= 1'b1;
    @(posedge clk); #1; chk("sleep held", {15'h0, sleep_ok}, 16'h0);
    @(posedge clk); mem_rd <= 1'b1; mem_section <= NPC_SEC_EE;
    @(posedge clk); mem_rd <= 1'b0;
    #1 chk("stall", {15'h0, mem_wait}, 16'h1);
    k = 0;
    do begin @(posedge clk); #1; k++; end while (mem_rvalid !== 1'b1 && k < 60);
    chk("stalled load", {7'h0, mem_rvalid, mem_rdata}, 16'h01A5);
    repeat (2) @(posedge clk); #1; chk("sleep", {15'h0, sleep_ok}, 16'h1);
    sleep_req <= 1'b0;
    $display("test stall done");
    wr(NPC_OFS_ADDRL, 8'h01); wr(NPC_OFS_DATAL, 8'h55); cmd(NPC_CMD_WFU); exp_none();
    @(posedge clk); port_access <= 1'b1;
    wr(NPC_OFS_ADDRL, 8'h01); wr(NPC_OFS_DATAL, 8'h55); cmd(NPC_CMD_WFU); wait_start();
    chk("fuse op", {13'h0, array_op}, 16'h7);
    idle_wait(); port_access <= 1'b0;
    store(NPC_SEC_CODE, 16'h0200, 8'h12); cmd(NPC_CMD_WP); wait_start();
    do_reset(1'b0); repeat (2) @(posedge clk);
    rd(NPC_OFS_STATUS, v); chk("aborted", {7'h0, cpu_halt, v & 8'h03}, 16'h0);
    @(posedge clk); exec_section <= NPC_SEC_DATA; store(NPC_SEC_EE, 16'h0004, 8'h01);
    repeat (2) @(posedge clk); #1; chk("data wr", {15'h0, write_error}, 16'h1);
    do_reset(1'b0); repeat (2) @(posedge clk); exec_section <= NPC_SEC_CODE;
    store(NPC_SEC_CODE, 16'h0300, 8'h01);
    repeat (2) @(posedge clk); #1; chk("code wr", {15'h0, write_error}, 16'h1);
    do_reset(1'b0); repeat (2) @(posedge clk); exec_section <= NPC_SEC_BOOT;
    wr(NPC_OFS_CCP, NPC_KEY_IO_UNLOCK_KEY); wr(NPC_OFS_CONTROL_B, 8'h01);
    rd(NPC_OFS_CONTROL_B, v); chk("protect set", {8'h0, v & 8'h01}, 16'h1);
    store(NPC_SEC_CODE, 16'h0300, 8'h01);
    repeat (2) @(posedge clk); #1; chk("protected", {15'h0, write_error}, 16'h1);
    $display("test protection done");
    end_sim();
  end
endmodule
`default_nettype wire
